// ---- rtl/csr_config_select.sv ----
`timescale 1ns/100ps
module csr_config_select
  import csr_pkg::*;
#(
  parameter int unsigned HOLDOFF = HOLDOFF_CYCLES
)(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       strap_refout_pin_i,
  output logic            strap_refout_pin_o,
  output logic            strap_refout_pin_oe,
  input  wire logic       sel_hi_sda_pin_i,
  output logic            sel_hi_sda_pin_o,
  output logic            sel_hi_sda_pin_oe,
  input  wire logic       sel_lo_scl_pin_i,
  input  wire logic       input_select_pin,
  input  wire logic       crystal_or_single_input,
  input  wire logic       differential_ref_input,
  input  wire logic       serial_defaults_flag,
  output logic            cfg_load_q,
  output logic [1:0]      cfg_index_q,
  output logic            cfg_use_defaults_q,
  output logic            cfg_applying,
  output logic            pll_ref_clk,
  output logic            pll_ref_is_diff
);

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  logic [1:0] strap_sync_q;
  logic [1:0] pin8_sync_q;
  logic [1:0] pin9_sync_q;
  logic [1:0] insel_sync_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_sync_q <= 2'h0;
      pin8_sync_q  <= 2'h3;
      pin9_sync_q  <= 2'h3;
      insel_sync_q <= 2'h0;
    end else begin
      strap_sync_q <= {strap_sync_q[0], strap_refout_pin_i};
      pin8_sync_q  <= {pin8_sync_q[0], sel_hi_sda_pin_i};
      pin9_sync_q  <= {pin9_sync_q[0], sel_lo_scl_pin_i};
      insel_sync_q <= {insel_sync_q[0], input_select_pin};
    end
  end

  // ***************************************************************
  // Strap capture
  // ***************************************************************
  logic [1:0] strap_cnt_q;
  logic       strap_done_q;
  logic       strap_q;
  logic       init_load;

  // Waits for the synchroniser to fill, then latches exactly once
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_cnt_q  <= 2'h0;
      strap_done_q <= 1'b0;
      strap_q      <= 1'b0;
    end else if (!strap_done_q) begin
      if (strap_cnt_q == STRAP_SETTLE) begin
        strap_q      <= strap_sync_q[1];
        strap_done_q <= 1'b1;
      end else begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
      end
    end
  end

  assign init_load = (strap_cnt_q == STRAP_SETTLE) && !strap_done_q;

  // ***************************************************************
  // Serial target on the shared pins
  // ***************************************************************
  logic           ser_en;
  logic           scl_prev_q;
  logic           sda_prev_q;
  logic           scl_rise;
  logic           scl_fall;
  logic           start_det;
  logic           stop_det;
  csr_ser_state_t ser_q;
  logic [3:0]     bitcnt_q;
  logic [7:0]     shift_q;
  logic [7:0]     tx_q;
  logic [7:0]     ptr_q;
  logic           ptr_set_q;
  logic           rw_q;
  logic           nack_q;
  logic           wr_q;
  logic [7:0]     wr_addr_q;
  logic [7:0]     wr_data_q;
  logic [7:0]     reg_ctrl_q;
  logic [7:0]     status;
  logic [7:0]     rd_next;

  // Serial access is blocked until the strap is known and low
  assign ser_en    = strap_done_q && !strap_q;
  assign scl_rise  = pin9_sync_q[1] && !scl_prev_q;
  assign scl_fall  = !pin9_sync_q[1] && scl_prev_q;
  assign start_det = pin9_sync_q[1] && scl_prev_q && sda_prev_q && !pin8_sync_q[1];
  assign stop_det  = pin9_sync_q[1] && scl_prev_q && !sda_prev_q && pin8_sync_q[1];

  // Read data for a register pointer
  function automatic logic [7:0] read_reg(input logic [7:0] ofs,
                                          input logic [7:0] ctrl,
                                          input logic [7:0] stat);
    logic [7:0] val;
    val = UNMAPPED_VALUE;
    if (ofs == REF_SRC_CTRL_OFS) begin
      val = ctrl;
    end else if (ofs == STATUS_OFS) begin
      val = stat;
    end
    return val;
  endfunction

  // Byte sent next when the pointer is read; a select on a call is not legal
  assign rd_next = read_reg(ptr_q, reg_ctrl_q, status);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= pin9_sync_q[1];
      sda_prev_q <= pin8_sync_q[1];
    end
  end

  // Byte engine: sample on SCL rise, drive on SCL fall
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ser_q             <= CSR_IDLE;
      bitcnt_q          <= 4'h0;
      shift_q           <= 8'h00;
      tx_q              <= 8'h00;
      ptr_q             <= 8'h00;
      ptr_set_q         <= 1'b0;
      rw_q              <= 1'b0;
      nack_q            <= 1'b0;
      wr_q              <= 1'b0;
      wr_addr_q         <= 8'h00;
      wr_data_q         <= 8'h00;
      sel_hi_sda_pin_oe <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      if (!ser_en || stop_det) begin
        ser_q             <= CSR_IDLE;
        sel_hi_sda_pin_oe <= 1'b0;
      end else if (start_det) begin
        ser_q             <= CSR_ADDR;
        bitcnt_q          <= 4'h0;
        ptr_set_q         <= 1'b0;
        sel_hi_sda_pin_oe <= 1'b0;
      end else if (scl_rise) begin
        if (ser_q == CSR_ADDR || ser_q == CSR_WR || ser_q == CSR_RD) begin
          shift_q  <= {shift_q[6:0], pin8_sync_q[1]};
          bitcnt_q <= bitcnt_q + 4'h1;
        end
        if (ser_q == CSR_RD_ACK) begin
          nack_q <= pin8_sync_q[1];
        end
      end else if (scl_fall) begin
        unique case (ser_q)
          CSR_IDLE: begin
          end
          CSR_ADDR: begin
            if (bitcnt_q == BITS_PER_BYTE) begin
              if (shift_q[7:1] == TARGET_ADDR) begin
                rw_q              <= shift_q[0];
                ser_q             <= CSR_ADDR_ACK;
                sel_hi_sda_pin_oe <= 1'b1;
              end else begin
                ser_q <= CSR_IDLE;
              end
            end
          end
          CSR_ADDR_ACK, CSR_WR_ACK: begin
            bitcnt_q <= 4'h0;
            if (rw_q) begin
              tx_q              <= rd_next;
              sel_hi_sda_pin_oe <= !rd_next[7];
              ptr_q             <= ptr_q + 8'h01;
              ser_q             <= CSR_RD;
            end else begin
              sel_hi_sda_pin_oe <= 1'b0;
              ser_q             <= CSR_WR;
            end
          end
          CSR_WR: begin
            if (bitcnt_q == BITS_PER_BYTE) begin
              sel_hi_sda_pin_oe <= 1'b1;
              ser_q             <= CSR_WR_ACK;
              if (!ptr_set_q) begin
                ptr_q     <= shift_q;
                ptr_set_q <= 1'b1;
              end else begin
                wr_q      <= 1'b1;
                wr_addr_q <= ptr_q;
                wr_data_q <= shift_q;
                ptr_q     <= ptr_q + 8'h01;
              end
            end
          end
          CSR_RD: begin
            if (bitcnt_q == BITS_PER_BYTE) begin
              sel_hi_sda_pin_oe <= 1'b0;
              ser_q             <= CSR_RD_ACK;
            end else begin
              tx_q              <= {tx_q[6:0], 1'b0};
              sel_hi_sda_pin_oe <= !tx_q[6];
            end
          end
          CSR_RD_ACK: begin
            if (nack_q) begin
              ser_q <= CSR_IDLE;
            end else begin
              bitcnt_q          <= 4'h0;
              tx_q              <= rd_next;
              sel_hi_sda_pin_oe <= !rd_next[7];
              ptr_q             <= ptr_q + 8'h01;
              ser_q             <= CSR_RD;
            end
          end
        endcase
      end
    end
  end

  // Open drain: only ever pulls low
  assign sel_hi_sda_pin_o = 1'b0;

  // ***************************************************************
  // Register file
  // ***************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_ctrl_q <= REF_SRC_CTRL_RST;
    end else if (wr_q && wr_addr_q == REF_SRC_CTRL_OFS) begin
      reg_ctrl_q <= wr_data_q;
    end
  end

  // ***************************************************************
  // Configuration loading
  // ***************************************************************
  logic [HOLDOFF_W-1:0] holdoff_q;
  logic                 holdoff_done;
  logic [1:0]           sel_now;
  logic [1:0]           sel_prev_q;
  logic                 hw_change;
  logic                 cmd_load;
  logic [APPLY_W-1:0]   apply_q;

  // Counts from reset release; saturates at the hold-off figure
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      holdoff_q <= '0;
    end else if (!holdoff_done) begin
      holdoff_q <= holdoff_q + 1'b1;
    end
  end

  assign holdoff_done = (holdoff_q >= HOLDOFF[HOLDOFF_W-1:0]);
  assign sel_now      = {pin8_sync_q[1], pin9_sync_q[1]};
  // Host must move one pin at a time, else a middle code may load
  assign hw_change    = strap_done_q && strap_q && !serial_defaults_flag &&
                        holdoff_done && (sel_now != sel_prev_q);
  assign cmd_load     = wr_q && (wr_addr_q == CFG_CMD_OFS);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_prev_q <= 2'h0;
    end else begin
      sel_prev_q <= sel_now;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_load_q         <= 1'b0;
      cfg_index_q        <= 2'h0;
      cfg_use_defaults_q <= 1'b0;
    end else begin
      cfg_load_q <= init_load || hw_change || cmd_load;
      if (init_load) begin
        if (strap_sync_q[1]) begin
          cfg_index_q        <= sel_now;
          cfg_use_defaults_q <= 1'b0;
        end else begin
          cfg_index_q        <= 2'h0;
          cfg_use_defaults_q <= serial_defaults_flag;
        end
      end else if (hw_change) begin
        cfg_index_q        <= sel_now;
        cfg_use_defaults_q <= 1'b0;
      end else if (cmd_load) begin
        cfg_index_q        <= wr_data_q[CMD_IDX_LO +: 2];
        cfg_use_defaults_q <= wr_data_q[CMD_DEFAULTS_BIT];
      end
    end
  end

  // Apply window, closes about 17 cycles inside the host's quiet time
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      apply_q <= '0;
    end else if (cfg_load_q) begin
      apply_q <= APPLY_W'(APPLY_CYCLES - 1);
    end else if (apply_q != '0) begin
      apply_q <= apply_q - 1'b1;
    end
  end

  assign cfg_applying = (apply_q != '0);

  // ***************************************************************
  // Reference selection
  // ***************************************************************
  logic want_diff_q;
  logic refout_q;

  // Outside manual mode the last choice is held
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      want_diff_q <= 1'b0;
    end else if (!reg_ctrl_q[SM_HI_BIT]) begin
      want_diff_q <= reg_ctrl_q[PRIM_SRC_BIT] ^ insel_sync_q[1];
    end
  end

  csr_ref_switch u_switch (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .ref_xtal      (crystal_or_single_input),
    .ref_diff      (differential_ref_input),
    .want_diff     (want_diff_q),
    .ref_out_q     (refout_q),
    .active_diff_q (pll_ref_is_diff)
  );

  assign pll_ref_clk = refout_q;

  // Strap pin turns into the reference output once latched
  assign strap_refout_pin_oe = strap_done_q;
  assign strap_refout_pin_o  = strap_done_q && refout_q;

  // ***************************************************************
  // Status
  // ***************************************************************
  always_comb begin
    status                       = 8'h00;
    status[ST_STRAP_BIT]         = strap_q;
    status[ST_IDX_LO +: 2]       = cfg_index_q;
    status[ST_DEFAULTS_BIT]      = cfg_use_defaults_q;
    status[ST_HOLDOFF_BIT]       = holdoff_done;
    status[ST_DIFF_BIT]          = pll_ref_is_diff;
    status[ST_APPLY_BIT]         = cfg_applying;
  end

endmodule

// ---- rtl/csr_pkg.sv ----
package csr_pkg;

  // ***************************************************************
  // Clock and timing
  // ***************************************************************
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned HOLDOFF_MS      = 10;
  localparam int unsigned HOLDOFF_CYCLES  = (CLK_HZ / 1000) * HOLDOFF_MS;
  localparam int unsigned HOLDOFF_W       = 17;
  localparam int unsigned APPLY_MS        = 1;
  localparam int unsigned APPLY_CYCLES    = (CLK_HZ / 1000) * APPLY_MS;
  localparam int unsigned APPLY_W         = 14;
  localparam logic [1:0]  STRAP_SETTLE    = 2'h3;

  // ***************************************************************
  // Serial target
  // ***************************************************************
  localparam logic [6:0]  TARGET_ADDR     = 7'h6A;
  localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [7:0]  REF_SRC_CTRL_OFS = 8'h13;
  localparam logic [7:0]  CFG_CMD_OFS      = 8'h14;
  localparam logic [7:0]  STATUS_OFS       = 8'h15;
  localparam logic [7:0]  REF_SRC_CTRL_RST = 8'h00;
  localparam logic [7:0]  UNMAPPED_VALUE   = 8'h00;

  // Reference source control fields
  localparam int unsigned PRIM_SRC_BIT    = 1;
  localparam int unsigned SM_HI_BIT       = 7;
  localparam int unsigned SM_LO_BIT       = 6;

  // Config command fields
  localparam int unsigned CMD_IDX_LO      = 0;
  localparam int unsigned CMD_DEFAULTS_BIT = 2;

  // Status fields
  localparam int unsigned ST_STRAP_BIT    = 0;
  localparam int unsigned ST_IDX_LO       = 1;
  localparam int unsigned ST_DEFAULTS_BIT = 3;
  localparam int unsigned ST_HOLDOFF_BIT  = 4;
  localparam int unsigned ST_DIFF_BIT     = 5;
  localparam int unsigned ST_APPLY_BIT    = 6;

  typedef enum logic [2:0] {
    CSR_IDLE,
    CSR_ADDR,
    CSR_ADDR_ACK,
    CSR_WR,
    CSR_WR_ACK,
    CSR_RD,
    CSR_RD_ACK
  } csr_ser_state_t;

endpackage

// ---- rtl/csr_ref_switch.sv ----
`timescale 1ns/100ps
module csr_ref_switch
  import csr_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic ref_xtal,
  input  wire logic ref_diff,
  input  wire logic want_diff,
  output logic      ref_out_q,
  output logic      active_diff_q
);

  logic [1:0] xtal_sync_q;
  logic [1:0] diff_sync_q;
  logic       gate_q;
  logic       cur_level;
  logic       new_level;

  // ***************************************************************
  // Input sampling
  // ***************************************************************
  // Both references are foreign to clk, two stages each
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      xtal_sync_q <= 2'h0;
      diff_sync_q <= 2'h0;
    end else begin
      xtal_sync_q <= {xtal_sync_q[0], ref_xtal};
      diff_sync_q <= {diff_sync_q[0], ref_diff};
    end
  end

  assign cur_level = active_diff_q ? diff_sync_q[1] : xtal_sync_q[1];
  assign new_level = active_diff_q ? xtal_sync_q[1] : diff_sync_q[1];

  // ***************************************************************
  // Break-before-make switch
  // ***************************************************************
  // Gate closes only while the old source is low; on a completed change it
  // reopens only while the new one is low, so no runt pulse reaches the output;
  // a request withdrawn while the gate is closed reopens it at once, whatever
  // the old source's level, so a cut-short high can then reach the output;
  // the price is a few missing periods during the change
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gate_q        <= 1'b1;
      active_diff_q <= 1'b0;
    end else if (want_diff != active_diff_q) begin
      if (gate_q && !cur_level) begin
        gate_q <= 1'b0;
      end else if (!gate_q && !new_level) begin
        active_diff_q <= want_diff;
        gate_q        <= 1'b1;
      end
    end else begin
      gate_q <= 1'b1;
    end
  end

  // Registered output keeps the edge free of mux hazards
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_out_q <= 1'b0;
    end else begin
      ref_out_q <= gate_q && cur_level;
    end
  end

endmodule

// ---- test/csr_config_select_checker.sv ----
`timescale 1ns/100ps
// ****
// Port checker
// ****
module csr_config_select_checker
  import csr_pkg::*;
#(
  parameter int unsigned HOLDOFF = HOLDOFF_CYCLES
)(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       strap_refout_pin_i,
  input wire logic       strap_refout_pin_o,
  input wire logic       strap_refout_pin_oe,
  input wire logic       sel_hi_sda_pin_i,
  input wire logic       sel_hi_sda_pin_o,
  input wire logic       sel_hi_sda_pin_oe,
  input wire logic       sel_lo_scl_pin_i,
  input wire logic       serial_defaults_flag,
  input wire logic       cfg_load_q,
  input wire logic [1:0] cfg_index_q,
  input wire logic       cfg_applying,
  input wire logic       pll_ref_clk,
  input wire logic       pll_ref_is_diff
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic hw_q;
  int   up_q;
  int   app_q;
  // Strap copy freezes once the pin turns output; the uptime count saturates, the apply count clears outside the window
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hw_q <= 1'b0;
      up_q <= 0;
      app_q <= 0;
    end else begin
      if (!strap_refout_pin_oe) hw_q <= strap_refout_pin_i;
      if (up_q < HOLDOFF + 8) up_q <= up_q + 1;
      app_q <= cfg_applying ? app_q + 1 : 0;
    end
  end
  property p_init; $rose(strap_refout_pin_oe) |-> cfg_load_q; endproperty
  a_init: assert property (p_init) else $error("no load at strap latch");
  property p_init_idx; $rose(strap_refout_pin_oe) && hw_q |-> cfg_index_q == {sel_hi_sda_pin_i, sel_lo_scl_pin_i};
  endproperty
  a_init_idx: assert property (p_init_idx) else $error("wrong power-up index");
  property p_oe_keep; strap_refout_pin_oe |=> strap_refout_pin_oe; endproperty
  a_oe_keep: assert property (p_oe_keep) else $error("ref output dropped");
  property p_oe_low; !strap_refout_pin_oe |-> !strap_refout_pin_o; endproperty
  a_oe_low: assert property (p_oe_low) else $error("pin value before latch");
  property p_refout; strap_refout_pin_oe |-> strap_refout_pin_o == pll_ref_clk; endproperty
  a_refout: assert property (p_refout) else $error("ref output not the reference");
  property p_hw_sda; hw_q |-> !sel_hi_sda_pin_oe; endproperty
  a_hw_sda: assert property (p_hw_sda) else $error("data line driven in select mode");
  property p_sda_od; !sel_hi_sda_pin_o; endproperty
  a_sda_od: assert property (p_sda_od) else $error("data line driven high");
  property p_quiet; hw_q && $past(strap_refout_pin_oe) && up_q < HOLDOFF |-> !cfg_load_q; endproperty
  a_quiet: assert property (p_quiet) else $error("load inside hold-off");
  property p_sel;
    hw_q && !serial_defaults_flag && up_q > HOLDOFF + 4 && $changed({sel_hi_sda_pin_i, sel_lo_scl_pin_i})
      |-> ##[1:4] (cfg_load_q && cfg_index_q == {sel_hi_sda_pin_i, sel_lo_scl_pin_i});
  endproperty
  a_sel: assert property (p_sel) else $error("select change not loaded");
  property p_app_on; cfg_load_q |=> cfg_applying; endproperty
  a_app_on: assert property (p_app_on) else $error("apply window missing");
  property p_app_len; $fell(cfg_applying) |-> app_q == APPLY_CYCLES - 1; endproperty
  a_app_len: assert property (p_app_len) else $error("apply window length");
  property p_app_cap; cfg_applying |-> app_q < APPLY_CYCLES; endproperty
  a_app_cap: assert property (p_app_cap) else $error("apply window too long");
  property p_glitch; up_q > 20 && $rose(pll_ref_clk) |-> pll_ref_clk [*3]; endproperty
  a_glitch: assert property (p_glitch) else $error("short reference pulse");
  cover property (hw_q && cfg_load_q && up_q > HOLDOFF);
  cover property (sel_hi_sda_pin_oe);
  cover property ($rose(pll_ref_is_diff));
endmodule

// ---- test/csr_config_select_tb.sv ----
`timescale 1ns/100ps
module csr_config_select_tb;
  import csr_pkg::*;
  localparam int unsigned HOLD = 200;
  logic       clk;
  logic       sys_rst;
  logic       isel;
  logic       xin;
  logic       din;
  logic       flag;
  logic       s_o, s_oe, d_o, d_oe, ld, defs, app, rclk, rdiff;
  logic [1:0] idx;
  logic [7:0] r;
  logic [7:0] v;
  logic [2:0] exq[$];
  int         rc;
  int         fails;
  int         num_checks;
  wire        strap_h;
  wire        sda_h;
  wire        scl_h;
  wire        strap_w = s_oe ? s_o : strap_h;
  wire        sda_w = sda_h & ~(d_oe & ~d_o);
  csr_host_model h (.clk(clk), .sda_in(sda_w), .strap(strap_h), .sda(sda_h), .scl(scl_h));
  csr_config_select #(.HOLDOFF(HOLD)) dut (
    .clk(clk), .sys_rst(sys_rst), .strap_refout_pin_i(strap_w), .strap_refout_pin_o(s_o),
    .strap_refout_pin_oe(s_oe), .sel_hi_sda_pin_i(sda_w), .sel_hi_sda_pin_o(d_o), .sel_hi_sda_pin_oe(d_oe),
    .sel_lo_scl_pin_i(scl_h), .input_select_pin(isel), .crystal_or_single_input(xin),
    .differential_ref_input(din), .serial_defaults_flag(flag), .cfg_load_q(ld), .cfg_index_q(idx),
    .cfg_use_defaults_q(defs), .cfg_applying(app), .pll_ref_clk(rclk), .pll_ref_is_diff(rdiff));
  initial clk = 1'b0;
  always #50 clk = ~clk;
  // Two unrelated references, half periods of 4 and 3 clocks
  always @(posedge clk) begin
    #10;
    rc++;
    xin = (rc % 8) < 4;
    din = (rc % 6) < 3;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Each load must match the oldest expected one; a stray load meets x.
  // Looked at mid-cycle, away from the edge that launches it
  always @(negedge clk) begin
    if (!sys_rst && ld === 1'b1) chk({5'h0, defs, idx}, exq.size() > 0 ? {5'h0, exq.pop_front()} : 8'hxx);
  end
  task automatic rst(input logic s, input logic hi, input logic lo, input logic f);
    sys_rst = 1'b1;
    h.pins(s, hi, lo);
    flag = f;
    exq.delete();
    h.w(2);
    sys_rst = 1'b0;
    exq.push_back(s ? {1'b0, hi, lo} : {f, 2'b00});
    h.w(12);
    chk(8'(exq.size()), 8'h00);
    chk({7'h0, s_oe}, 8'h01);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] rb;
    logic       k;
    h.start();
    h.xfer({TARGET_ADDR, 1'b0}, 1'b1, rb, k);
    chk({7'h0, k}, 8'h00);
    h.xfer(a, 1'b1, rb, k);
    h.xfer(d, 1'b1, rb, k);
    chk({7'h0, k}, 8'h00);
    h.stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic k;
    h.start();
    h.xfer({TARGET_ADDR, 1'b0}, 1'b1, d, k);
    h.xfer(a, 1'b1, d, k);
    h.start();
    h.xfer({TARGET_ADDR, 1'b1}, 1'b1, d, k);
    h.xfer(8'hff, 1'b1, d, k);
    h.stop();
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog well above the expected run of about 45k cycles
  initial begin
    repeat (60_000) @(posedge clk);
    fails++;
    test_done();
  end
  initial begin
    sys_rst = 1'b1;
    isel = 1'b0;
    flag = 1'b0;
    xin = 1'b0;
    din = 1'b0;
    rc = 0;
    fails = 0;
    num_checks = 0;
    void'($urandom(32'hb210));
    // Power-up table: four select codes, then both flag values
    for (int k = 0; k < 6; k++) rst(k < 4, k[1], k[0], k > 4);
    $display("test power-up table done");
    rst(1'b1, 1'b0, 1'b0, 1'b0);
    h.sel(1'b0, 1'b1);
    exq.push_back(3'b011);
    h.sel(1'b1, 1'b1);
    chk({7'h0, app}, 8'h00);
    exq.push_back(3'b010);
    h.sel(1'b1, 1'b0);
    flag = 1'b1;
    h.sel(1'b1, 1'b1);
    chk(8'(exq.size()), 8'h00);
    $display("test select pins done");
    rst(1'b0, 1'b1, 1'b1, 1'b0);
    rd(REF_SRC_CTRL_OFS, r);
    chk(r, REF_SRC_CTRL_RST);
    rd(8'h20, r);
    chk(r, UNMAPPED_VALUE);
    for (int k = 0; k < 4; k++) begin
      v = {2'b00, 6'($urandom)};
      v[PRIM_SRC_BIT] = k[1];
      wr(REF_SRC_CTRL_OFS, v);
      rd(REF_SRC_CTRL_OFS, r);
      chk(r, v);
      isel = k[0];
      h.w(40);
      chk({7'h0, rdiff}, {7'h0, k[1] ^ k[0]});
    end
    // Automatic mode must freeze the pin-driven choice
    wr(REF_SRC_CTRL_OFS, 8'h80);
    h.w(40);
    chk({7'h0, rdiff}, 8'h00);
    wr(REF_SRC_CTRL_OFS, 8'h00);
    h.w(40);
    chk({7'h0, rdiff}, 8'h01);
    // Serial command is the only way to a new configuration here
    v = 8'($urandom);
    exq.push_back({v[CMD_DEFAULTS_BIT], v[CMD_IDX_LO +: 2]});
    wr(CFG_CMD_OFS, v);
    h.w(4);
    chk(8'(exq.size()), 8'h00);
    $display("test serial and reference done");
    test_done();
  end
endmodule
bind csr_config_select csr_config_select_checker #(.HOLDOFF(HOLDOFF)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .strap_refout_pin_i(strap_refout_pin_i), .strap_refout_pin_o(strap_refout_pin_o),
  .strap_refout_pin_oe(strap_refout_pin_oe), .sel_hi_sda_pin_i(sel_hi_sda_pin_i),
  .sel_hi_sda_pin_o(sel_hi_sda_pin_o), .sel_hi_sda_pin_oe(sel_hi_sda_pin_oe), .sel_lo_scl_pin_i(sel_lo_scl_pin_i),
  .serial_defaults_flag(serial_defaults_flag), .cfg_load_q(cfg_load_q), .cfg_index_q(cfg_index_q),
  .cfg_applying(cfg_applying), .pll_ref_clk(pll_ref_clk), .pll_ref_is_diff(pll_ref_is_diff));

// ---- test/csr_host_model.sv ----
`timescale 1ns/100ps
// ****
// Host GPIO and serial master
// ****
module csr_host_model
  import csr_pkg::*;
(
  input  wire logic clk,
  input  wire logic sda_in,
  output logic      strap,
  output logic      sda,
  output logic      scl
);
  // Levels held on the pins through a power-on reset
  task automatic pins(input logic s, input logic hi, input logic lo);
    strap = s;
    sda = hi;
    scl = lo;
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask
  // One pin per move, then leave the part alone past the apply time
  task automatic sel(input logic hi, input logic lo);
    if (sda !== hi) begin
      sda = hi;
      w(APPLY_CYCLES + 20);
    end
    if (scl !== lo) begin
      scl = lo;
      w(APPLY_CYCLES + 20);
    end
  endtask
  // Data moves one clock after the clock line falls, never with it
  task automatic bit_io(input logic b, output logic r);
    sda = b;
    w(4);
    scl = 1'b1;
    w(3);
    r = sda_in;
    w(2);
    scl = 1'b0;
    w(1);
  endtask
  task automatic start();
    sda = 1'b1;
    w(5);
    scl = 1'b1;
    w(5);
    sda = 1'b0;
    w(5);
    scl = 1'b0;
    w(1);
  endtask
  task automatic stop();
    sda = 1'b0;
    w(5);
    scl = 1'b1;
    w(5);
    sda = 1'b1;
    w(5);
  endtask
  task automatic xfer(input logic [7:0] wb, input logic ai, output logic [7:0] rb, output logic ao);
    for (int i = 7; i >= 0; i--) bit_io(wb[i], rb[i]);
    bit_io(ai, ao);
  endtask
endmodule
